// *** core/drive_ctrl.sv ***
// drive enable gate, software enable rules, comm watchdog and unit selects
//
// How it works
// - can bit rate takes only the eleven listed kbaud values; 500 after reset
// - output stage enabled only when hardware enable AND software enable
// - auto enable bit, 0 inactive 1 active, default 1, sets software enable
// - analog command modes 1 and 3 set software enable at power-on
// - digital command modes load software enable from auto enable at power-on
// - clearing a resettable fault reloads software enable from auto enable
// - watchdog period in ms, 1 to 32000, default 100
// - watchdog runs only when period nonzero and output stage enabled
// - expiry raises warning and stops motion; stage stays enabled
// - motion commands refused while warning pending; clear fault or input 14 clears
// - accel unit codes 0 to 5 decoded as rise time, rad, rpm, position units
// - accel unit drives path generator ramps and velocity mode ramps
// - accel unit change converts global ramps only, never motion blocks
// - velocity unit codes 0 to 6, 8, 9 accepted and decoded
// - speed parameters are 32-bit fixed point with three decimals
// - velocity parameters are 32-bit integers without fraction
// - position unit codes 0 to 9: counts, then dm down to nm
// - position unit counts means scaling from position gearing only
`timescale 1ns/1ps
`include "drive_ctrl_defs.svh"

module drive_ctrl
  import drive_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = `CLK_FREQ_KHZ * `WD_TICK_MS
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hw_enable_pin,
  input  wire logic        din_fault_reset,
  input  wire logic        din_wd_clear,
  input  wire logic [3:0]  command_mode,
  input  wire logic        resettable_fault,
  input  wire logic        wd_trigger,
  input  wire logic        motion_cmd_valid,
  output logic             stage_enable,
  output logic             sw_enable,
  output logic             wd_warning,
  output logic             motion_stop,
  output logic             motion_cmd_accept,
  output logic             fault_clear,
  output logic [10:0]      can_bit_rate_sel,
  output unit_sel_type     units,
  output logic             pos_gear_only,
  output logic [1:0]       speed_frac_digits,
  output logic             ramp_convert,
  output logic [2:0]       ramp_unit_old,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic       hw_s1_r;
  logic       hw_s2_r;
  logic       d1_s1_r;
  logic       d1_s2_r;
  logic       d1_s3_r;
  logic       d14_s1_r;
  logic       d14_s2_r;
  logic       d14_s3_r;
  logic [3:0] mode_s1_r;
  logic [3:0] mode_s2_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hw_s1_r   <= 1'b0;
      hw_s2_r   <= 1'b0;
      d1_s1_r   <= 1'b0;
      d1_s2_r   <= 1'b0;
      d1_s3_r   <= 1'b0;
      d14_s1_r  <= 1'b0;
      d14_s2_r  <= 1'b0;
      d14_s3_r  <= 1'b0;
      mode_s1_r <= 4'h0;
      mode_s2_r <= 4'h0;
    end
    else
    begin
      hw_s1_r   <= hw_enable_pin;
      hw_s2_r   <= hw_s1_r;
      d1_s1_r   <= din_fault_reset;
      d1_s2_r   <= d1_s1_r;
      d1_s3_r   <= d1_s2_r;
      d14_s1_r  <= din_wd_clear;
      d14_s2_r  <= d14_s1_r;
      d14_s3_r  <= d14_s2_r;
      mode_s1_r <= command_mode;
      mode_s2_r <= mode_s1_r;
    end
  end

  logic d1_rise;
  logic d14_rise;

  assign d1_rise  = d1_s2_r & ~d1_s3_r;
  assign d14_rise = d14_s2_r & ~d14_s3_r;

  ////////////////////////////////////////////////////////////////////////
  // apb register file

  logic [31:0]    prdata_r;
  logic [31:0]    prdata_nxt;
  logic           pready_r;
  logic           pready_nxt;
  logic           pslverr_r;
  logic           pslverr_nxt;
  logic           auto_en_r;
  logic           auto_en_nxt;
  unit_sel_type   units_r;
  unit_sel_type   units_nxt;
  logic [10:0]    can_r;
  logic [10:0]    can_nxt;
  logic [14:0]    wd_period_r;
  logic [14:0]    wd_period_nxt;
  logic [`IRQ_BITS-1:0] istat_r;
  logic [`IRQ_BITS-1:0] istat_nxt;
  logic [`IRQ_BITS-1:0] imask_r;
  logic [`IRQ_BITS-1:0] imask_nxt;
  logic           cmd_wr;
  logic [31:0]    status_word;
  logic           wr_go;
  logic           setup;
  logic           mapped;
  logic           accel_chg;
  logic [`IRQ_BITS-1:0] ievents;

  // shared with the enable and watchdog groups
  logic           sw_en_r;
  logic           stage_r;
  logic           warn_r;
  logic           wd_run_r;
  logic           clear_evt;
  logic           reload_evt;
  logic           expire;

  function automatic logic can_ok(input logic [10:0] v);
    case (v)
      11'h00A, 11'h014, 11'h032, 11'h064, 11'h07D, 11'h0FA,
      11'h14D, 11'h1F4, 11'h29A, 11'h320, 11'h3E8: can_ok = 1'b1;
      default: can_ok = 1'b0;
    endcase
  endfunction : can_ok

  assign setup  = psel & ~penable;
  assign wr_go  = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign cmd_wr = wr_go & (paddr == `A_COMMAND);
  assign mapped = (paddr == `A_CONFIG) | (paddr == `A_CAN_RATE)
                | (paddr == `A_WD_PERIOD) | (paddr == `A_COMMAND)
                | (paddr == `A_STATUS) | (paddr == `A_IRQ_STATUS)
                | (paddr == `A_IRQ_MASK);

  always_comb
  begin
    status_word    = 32'h0000_0000;
    status_word[0] = sw_en_r;
    status_word[1] = stage_r;
    status_word[2] = warn_r;
    status_word[3] = wd_run_r;
    status_word[4] = hw_s2_r;
    status_word[11:8] = mode_s2_r;
  end

  assign ievents = {accel_chg, reload_evt, expire};

  always_comb
  begin
    prdata_nxt    = prdata_r;
    pready_nxt    = setup;
    pslverr_nxt   = setup & ~mapped;
    auto_en_nxt   = auto_en_r;
    units_nxt     = units_r;
    can_nxt       = can_r;
    wd_period_nxt = wd_period_r;
    imask_nxt     = imask_r;
    istat_nxt     = istat_r;
    accel_chg     = 1'b0;
    // read data is latched in the setup cycle so prdata leaves a flop
    if (setup & ~pwrite)
    begin
      case (paddr)
        `A_CONFIG:
          prdata_nxt = {16'h0000, units_r.pos, units_r.vel, 1'b0,
                        units_r.accel, 3'h0, auto_en_r};
        `A_CAN_RATE:   prdata_nxt = {21'h00_0000, can_r};
        `A_WD_PERIOD:  prdata_nxt = {17'h0_0000, wd_period_r};
        `A_STATUS:     prdata_nxt = status_word;
        `A_IRQ_STATUS: prdata_nxt = {29'h0000_0000, istat_r};
        `A_IRQ_MASK:   prdata_nxt = {29'h0000_0000, imask_r};
        default:       prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_go)
    begin
      case (paddr)
        `A_CONFIG:
        begin
          auto_en_nxt = pwdata[`F_AUTO_EN];
          // each unit field keeps its old code when given an unknown one
          if (pwdata[`F_ACCEL_LO+2:`F_ACCEL_LO] <= `ACCEL_MAX)
          begin
            units_nxt.accel = pwdata[`F_ACCEL_LO+2:`F_ACCEL_LO];
            accel_chg = (units_nxt.accel != units_r.accel);
          end
          if ((pwdata[`F_VEL_LO+3:`F_VEL_LO] <= `VEL_MAX)
              && (pwdata[`F_VEL_LO+3:`F_VEL_LO] != `VEL_HOLE))
          begin
            units_nxt.vel = pwdata[`F_VEL_LO+3:`F_VEL_LO];
          end
          if (pwdata[`F_POS_LO+3:`F_POS_LO] <= `POS_MAX)
          begin
            units_nxt.pos = pwdata[`F_POS_LO+3:`F_POS_LO];
          end
        end
        `A_CAN_RATE:
        begin
          if (can_ok(pwdata[10:0]))
          begin
            can_nxt = pwdata[10:0];
          end
        end
        `A_WD_PERIOD:
        begin
          // zero is kept: it parks the watchdog
          if (pwdata[31:15] == 17'h0_0000 && pwdata[14:0] <= `WD_PERIOD_MAX)
          begin
            wd_period_nxt = pwdata[14:0];
          end
        end
        `A_IRQ_STATUS: istat_nxt = istat_r & ~pwdata[`IRQ_BITS-1:0];
        `A_IRQ_MASK:   imask_nxt = pwdata[`IRQ_BITS-1:0];
        default:       istat_nxt = istat_r;
      endcase
    end
    // a new event wins over a write-one-to-clear in the same cycle
    istat_nxt = istat_nxt | ievents;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r    <= 32'h0000_0000;
      pready_r    <= 1'b0;
      pslverr_r   <= 1'b0;
      auto_en_r   <= `AUTO_EN_RST;
      units_r     <= '{pos: `POS_RST, vel: `VEL_RST, accel: `ACCEL_RST};
      can_r       <= `CAN_RATE_RST;
      wd_period_r <= `WD_PERIOD_RST;
      istat_r     <= '0;
      imask_r     <= '0;
    end
    else
    begin
      prdata_r    <= prdata_nxt;
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
      auto_en_r   <= auto_en_nxt;
      units_r     <= units_nxt;
      can_r       <= can_nxt;
      wd_period_r <= wd_period_nxt;
      istat_r     <= istat_nxt;
      imask_r     <= imask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software enable and output stage gate

  init_state_type st_r;
  init_state_type st_nxt;
  logic           sw_en_nxt;
  logic           stage_nxt;
  logic           analog_mode;

  assign analog_mode = (mode_s2_r == 4'h1) | (mode_s2_r == 4'h3);
  assign clear_evt   = (cmd_wr & pwdata[`C_CLR_FAULT]) | d1_rise;
  assign reload_evt  = clear_evt & resettable_fault;

  always_comb
  begin
    st_nxt    = st_r;
    sw_en_nxt = sw_en_r;
    case (st_r)
      // wait for the strapped mode to pass its synchroniser
      ST_SYNC0: st_nxt = ST_SYNC1;
      ST_SYNC1: st_nxt = ST_LOAD;
      ST_LOAD:
      begin
        st_nxt    = ST_RUN;
        sw_en_nxt = analog_mode ? 1'b1
                                : auto_en_r;
      end
      ST_RUN:
      begin
        if (reload_evt)
        begin
          sw_en_nxt = auto_en_r;
        end
        else if (cmd_wr & pwdata[`C_SW_CLR])
        begin
          sw_en_nxt = 1'b0;
        end
        else if (cmd_wr & pwdata[`C_SW_SET])
        begin
          sw_en_nxt = 1'b1;
        end
      end
      default: st_nxt = ST_SYNC0;
    endcase
    stage_nxt = hw_s2_r & sw_en_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r    <= ST_SYNC0;
      sw_en_r <= 1'b0;
      stage_r <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      sw_en_r <= sw_en_nxt;
      stage_r <= stage_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // communication watchdog

  logic [14:0] tick_r;
  logic [14:0] tick_nxt;
  logic [14:0] ms_r;
  logic [14:0] ms_nxt;
  logic        wd_run_nxt;
  logic        warn_nxt;
  logic        trig;
  logic        tick_end;
  logic        accept_r;
  logic        accept_nxt;
  logic        fclr_r;
  logic        conv_r;
  logic [2:0]  conv_old_r;
  logic        irq_r;
  logic        pgear_r;

  assign trig     = wd_trigger | (cmd_wr & pwdata[`C_WD_TRIG]);
  assign tick_end = (tick_r == 15'(TICK_CYCLES - 1));
  // a trigger in the last cycle still counts: it restarts rather than expires
  assign expire   = wd_run_r & stage_r & ~warn_r & ~trig & tick_end
                  & (ms_r == wd_period_r - 15'h0001);

  always_comb
  begin
    wd_run_nxt = (wd_period_r != 15'h0000) & stage_r;
    tick_nxt   = tick_r;
    ms_nxt     = ms_r;
    if (!wd_run_r || trig)
    begin
      tick_nxt = 15'h0000;
      ms_nxt   = 15'h0000;
    end
    else if (!warn_r)
    begin
      tick_nxt = tick_end ? 15'h0000 : tick_r + 15'h0001;
      if (tick_end)
      begin
        ms_nxt = ms_r + 15'h0001;
      end
    end
    warn_nxt = warn_r;
    // clearing loses to an expiry in the same cycle
    if ((cmd_wr & pwdata[`C_CLR_FAULT]) | d14_rise)
    begin
      warn_nxt = 1'b0;
    end
    if (expire)
    begin
      warn_nxt = 1'b1;
    end
    accept_nxt = motion_cmd_valid & ~warn_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_run_r <= 1'b0;
      tick_r   <= 15'h0000;
      ms_r     <= 15'h0000;
      warn_r   <= 1'b0;
      accept_r <= 1'b0;
    end
    else
    begin
      wd_run_r <= wd_run_nxt;
      tick_r   <= tick_nxt;
      ms_r     <= ms_nxt;
      warn_r   <= warn_nxt;
      accept_r <= accept_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ramp conversion strobe, fault clear strobe, interrupt

  // only global ramps follow a unit change; stored motion blocks do not
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv_r     <= 1'b0;
      conv_old_r <= `ACCEL_RST;
      fclr_r     <= 1'b0;
      irq_r      <= 1'b0;
      pgear_r    <= 1'b1;
    end
    else
    begin
      conv_r     <= accel_chg;
      conv_old_r <= accel_chg ? units_r.accel : conv_old_r;
      fclr_r     <= clear_evt;
      irq_r      <= |(istat_nxt & imask_nxt);
      pgear_r    <= (units_nxt.pos == `POS_RST);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign stage_enable      = stage_r;
  assign sw_enable         = sw_en_r;
  assign wd_warning        = warn_r;
  assign motion_stop       = warn_r;
  assign motion_cmd_accept = accept_r;
  assign fault_clear       = fclr_r;
  assign can_bit_rate_sel  = can_r;
  assign units             = units_r;
  assign pos_gear_only     = pgear_r;
  // speed values carry three decimals, velocity values none
  assign speed_frac_digits = `SPEED_FRAC_DIG;
  assign ramp_convert      = conv_r;
  assign ramp_unit_old     = conv_old_r;
  assign irq               = irq_r;

endmodule : drive_ctrl

// *** pkg/drive_ctrl_defs.svh ***
// register map, reset values, field positions and timing for the drive control block
`ifndef DRIVE_CTRL_DEFS_SVH
`define DRIVE_CTRL_DEFS_SVH

`define A_CONFIG       8'h00
`define A_CAN_RATE     8'h04
`define A_WD_PERIOD    8'h08
`define A_COMMAND      8'h0C
`define A_STATUS       8'h10
`define A_IRQ_STATUS   8'h14
`define A_IRQ_MASK     8'h18

`define F_AUTO_EN      0
`define F_ACCEL_LO     4
`define F_VEL_LO       8
`define F_POS_LO       12
`define C_SW_SET       0
`define C_SW_CLR       1
`define C_CLR_FAULT    2
`define C_WD_TRIG      3
`define I_WD_EXPIRE    0
`define I_FAULT_RELOAD 1
`define I_ACCEL_CHG    2
`define IRQ_BITS       3

`define AUTO_EN_RST    1'b1
`define ACCEL_RST      3'h0
`define VEL_RST        4'h0
`define POS_RST        4'h0
`define CAN_RATE_RST   11'h1F4
`define WD_PERIOD_RST  15'h0064
`define WD_PERIOD_MAX  15'h7D00
`define ACCEL_MAX      3'h5
`define POS_MAX        4'h9
`define VEL_HOLE       4'h7
`define VEL_MAX        4'h9
`define SPEED_FRAC_DIG 2'h3

`define CLK_FREQ_KHZ   25000
`define WD_TICK_MS     1

`endif

// *** pkg/drive_ctrl_pkg.sv ***
// types shared by the drive control block
package drive_ctrl_pkg;

  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] vel;
    logic [2:0] accel;
  } unit_sel_type;

  typedef enum logic [1:0] {
    ST_SYNC0,
    ST_SYNC1,
    ST_LOAD,
    ST_RUN
  } init_state_type;

endpackage : drive_ctrl_pkg

// *** verification/drive_ctrl_monitor.sv ***
// assertion checker on the drive control block ports
`timescale 1ns/1ps
module drive_ctrl_monitor
  import drive_ctrl_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         hw_enable_pin,
  input wire logic         wd_trigger,
  input wire logic         motion_cmd_valid,
  input wire logic         stage_enable,
  input wire logic         sw_enable,
  input wire logic         wd_warning,
  input wire logic         motion_stop,
  input wire logic         motion_cmd_accept,
  input wire logic [10:0]  can_bit_rate_sel,
  input wire unit_sel_type units,
  input wire logic         pos_gear_only,
  input wire logic [1:0]   speed_frac_digits,
  input wire logic         ramp_convert,
  input wire logic [2:0]   ramp_unit_old
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////
  a_stage_gate: assert property (stage_enable |-> sw_enable)
    else $error("stage on without software enable");
  // 2-ff sync plus register: four low samples must show
  a_hw_gate: assert property ((!hw_enable_pin)[*4] |-> !stage_enable)
    else $error("stage on with hardware enable low");
  a_stop_follows: assert property (motion_stop == wd_warning)
    else $error("motion stop differs from warning");
  a_cmd_refused: assert property (motion_cmd_accept |-> $past(motion_cmd_valid) && !$past(wd_warning))
    else $error("command accepted while warning pending");
  a_warn_stage: assert property ($rose(wd_warning) |-> stage_enable)
    else $error("warning raised with stage off");
  a_frac_fixed: assert property (speed_frac_digits == 2'h3)
    else $error("speed fraction digits wrong");
  a_gear_only: assert property (pos_gear_only == (units.pos == 4'h0))
    else $error("gear only flag wrong");
  a_can_legal: assert property (can_bit_rate_sel inside {11'd10, 11'd20, 11'd50, 11'd100, 11'd125,
    11'd250, 11'd333, 11'd500, 11'd666, 11'd800, 11'd1000})
    else $error("illegal can rate held");
  a_unit_legal: assert property (units.accel <= 3'h5 && units.vel != 4'h7 && units.vel <= 4'h9
    && units.pos <= 4'h9)
    else $error("illegal unit code held");
  a_ramp_conv: assert property (ramp_convert |-> ramp_unit_old != units.accel)
    else $error("ramp conversion without unit change");
  a_trig_restart: assert property ($rose(wd_warning) |-> !$past(wd_trigger))
    else $error("expiry right after trigger");
  c_warn: cover property ($rose(wd_warning));
  c_conv: cover property (ramp_convert);
  c_accept: cover property (motion_cmd_accept);
endmodule : drive_ctrl_monitor

bind drive_ctrl drive_ctrl_monitor mon (.pclk(pclk), .presetn(presetn), .hw_enable_pin(hw_enable_pin),
  .wd_trigger(wd_trigger), .motion_cmd_valid(motion_cmd_valid), .stage_enable(stage_enable),
  .sw_enable(sw_enable), .wd_warning(wd_warning), .motion_stop(motion_stop),
  .motion_cmd_accept(motion_cmd_accept), .can_bit_rate_sel(can_bit_rate_sel), .units(units),
  .pos_gear_only(pos_gear_only), .speed_frac_digits(speed_frac_digits), .ramp_convert(ramp_convert),
  .ramp_unit_old(ramp_unit_old));

// *** verification/comm_card_model.sv ***
// comm card model: periodic watchdog trigger and motion command offers
`timescale 1ns/1ps
module comm_card_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] trig_gap,
  input  wire logic       cmd_req,
  output logic            wd_trigger,
  output logic            motion_cmd_valid
);
  logic [7:0] cnt_r;
  // a gap of zero means the card has gone silent
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 8'h00;
      wd_trigger <= 1'b0;
      motion_cmd_valid <= 1'b0;
    end
    else
    begin
      wd_trigger <= (trig_gap != 8'h00) && (cnt_r == trig_gap);
      cnt_r <= (cnt_r >= trig_gap) ? 8'h00 : cnt_r + 8'h01;
      motion_cmd_valid <= cmd_req;
    end
  end
endmodule : comm_card_model

// *** verification/test_drive_enable_comm_watchdog_units.sv ***
// self-checking bench for the drive control block
`timescale 1ns/1ps
`include "drive_ctrl_defs.svh"
module test_drive_enable_comm_watchdog_units
  import drive_ctrl_pkg::*;
();
  typedef struct packed {logic [31:0] d; logic e; logic r;} exp_type;
  logic         pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00, gap = 8'h01;
  logic [31:0]  pwdata = 32'h0000_0000, prdata;
  logic         hw = 1'b1, di1 = 1'b0, di14 = 1'b0, flt = 1'b0, cmd = 1'b0;
  logic [3:0]   mode = 4'h2, pos_e, vel_e;
  logic [2:0]   acc_e, rold;
  logic         pready, pslverr, trig, mvalid, stage, swen, warn, mstop, acc, fclr, posg, rconv, irq;
  logic [10:0]  can;
  logic [1:0]   frac;
  unit_sel_type units;
  exp_type      expq[$], ex;
  int           miscompares = 0, comparisons = 0, fclr_cnt = 0;
  int           rates[11] = '{10, 20, 50, 100, 125, 250, 333, 500, 666, 800, 1000};
  always #20 pclk = ~pclk;
  drive_ctrl #(.TICK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_enable_pin(hw), .din_fault_reset(di1), .din_wd_clear(di14), .command_mode(mode),
    .resettable_fault(flt), .wd_trigger(trig), .motion_cmd_valid(mvalid), .stage_enable(stage),
    .sw_enable(swen), .wd_warning(warn), .motion_stop(mstop), .motion_cmd_accept(acc), .fault_clear(fclr),
    .can_bit_rate_sel(can), .units(units), .pos_gear_only(posg), .speed_frac_digits(frac),
    .ramp_convert(rconv), .ramp_unit_old(rold), .irq(irq));
  comm_card_model card (.pclk(pclk), .presetn(presetn), .trig_gap(gap), .cmd_req(cmd),
    .wd_trigger(trig), .motion_cmd_valid(mvalid));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input exp_type x);
    int n;
    expq.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      miscompares++;
      final_report();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '{32'h0, 1'b0, 1'b0});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, '{d, 1'b0, 1'b1});
  endtask : rd
  // bounded wait on warning (sel 0) or software enable
  task automatic wait_on(input int sel, input logic v);
    int n;
    n = 0;
    while (((sel == 0) ? warn : swen) !== v && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200)
    begin
      miscompares++;
      final_report();
    end
  endtask : wait_on
  // the auto enable write lands before the power-on load at the third edge
  task automatic do_reset(input logic [3:0] m, input logic ae);
    presetn <= 1'b0;
    mode <= m;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wr(`A_CONFIG, {31'h0000_0000, ae});
    @(posedge pclk);
  endtask : do_reset
  //////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
  begin
    fclr_cnt += (fclr === 1'b1);
    if (pready === 1'b1)
    begin
      if (expq.size() == 0)
        check(32'h0, 32'h1);
      else
      begin
        ex = expq.pop_front();
        if (ex.r)
          check(prdata, ex.d);
        check(32'(pslverr), 32'(ex.e));
      end
    end
  end
  initial
  begin
    void'($urandom(32'h1fb3));
    do_reset(4'h2, 1'b1);
    check(32'(swen), 32'h1);
    rd(`A_CONFIG, 32'h0000_0001);
    rd(`A_CAN_RATE, 32'h0000_01F4);
    rd(`A_WD_PERIOD, 32'h0000_0064);
    apb(1'b0, 8'h1C, 32'h0, '{32'h0, 1'b1, 1'b1});
    foreach (rates[i])
    begin
      wr(`A_CAN_RATE, 32'(rates[i]));
      rd(`A_CAN_RATE, 32'(rates[i]));
    end
    wr(`A_CAN_RATE, 32'($urandom_range(1001, 2047)));
    rd(`A_CAN_RATE, 32'h0000_03E8);
    $display("test reset_and_can done");
    {acc_e, vel_e, pos_e} = 11'h0;
    for (int i = 0; i < 16; i++)
    begin
      wr(`A_CONFIG, {16'h0, i[3:0], i[3:0], 1'b0, i[2:0], 4'h1});
      if (i[2:0] <= 3'h5) acc_e = i[2:0];
      if (i != 7 && i <= 9) vel_e = i[3:0];
      if (i <= 9) pos_e = i[3:0];
      rd(`A_CONFIG, {16'h0, pos_e, vel_e, 1'b0, acc_e, 4'h1});
      check(32'(units), 32'({pos_e, vel_e, acc_e}));
      check(32'(posg), 32'(pos_e == 4'h0));
    end
    $display("test units done");
    hw <= 1'b0;
    repeat (5) @(posedge pclk);
    check(32'(stage), 32'h0);
    hw <= 1'b1;
    wr(`A_COMMAND, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    check(32'(stage), 32'h0);
    wr(`A_COMMAND, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    check(32'(stage), 32'h1);
    wr(`A_CONFIG, 32'h0000_0000);
    flt <= 1'b1;
    wr(`A_COMMAND, 32'h0000_0004);
    repeat (2) @(posedge pclk);
    check(32'(swen), 32'h0);
    wr(`A_CONFIG, 32'h0000_0001);
    di1 <= 1'b1;
    wait_on(1, 1'b1);
    check(32'(swen), 32'h1);
    di1 <= 1'b0;
    flt <= 1'b0;
    @(posedge pclk);
    check(fclr_cnt, 2);
    $display("test enable done");
    wr(`A_IRQ_MASK, 32'h0000_0001);
    wr(`A_WD_PERIOD, 32'h0000_7D01);
    rd(`A_WD_PERIOD, 32'h0000_0064);
    wr(`A_WD_PERIOD, 32'h0000_7D00);
    rd(`A_WD_PERIOD, 32'h0000_7D00);
    gap <= 8'h00;
    wr(`A_WD_PERIOD, 32'h0000_0000);
    repeat (20) @(posedge pclk);
    check(32'(warn), 32'h0);
    // stage off: a silent card must not expire the watchdog
    wr(`A_COMMAND, 32'h0000_0002);
    wr(`A_WD_PERIOD, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    check(32'(warn), 32'h0);
    gap <= 8'h01;
    wr(`A_COMMAND, 32'h0000_0001);
    repeat (30) @(posedge pclk);
    check(32'(warn), 32'h0);
    gap <= 8'h00;
    repeat (10) wr(`A_COMMAND, 32'h0000_0008);
    check(32'(warn), 32'h0);
    wait_on(0, 1'b1);
    check(32'(stage), 32'h1);
    check(32'(mstop), 32'h1);
    check(32'(irq), 32'h1);
    cmd <= 1'b1;
    repeat (3) @(posedge pclk);
    check(32'(acc), 32'h0);
    gap <= 8'h01;
    di14 <= 1'b1;
    wait_on(0, 1'b0);
    repeat (3) @(posedge pclk);
    check(32'(acc), 32'h1);
    wr(`A_IRQ_STATUS, 32'h0000_0001);
    check(32'(irq), 32'h0);
    cmd <= 1'b0;
    di14 <= 1'b0;
    $display("test watchdog done");
    // auto enable cleared before the load: only analog modes still enable
    do_reset({2'b00, 1'($urandom_range(0, 1)), 1'b1}, 1'b0);
    check(32'(swen), 32'h1);
    do_reset(4'($urandom_range(4, 8)), 1'b0);
    check(32'(swen), 32'h0);
    do_reset(4'h0, 1'b1);
    check(32'(swen), 32'h1);
    rd(`A_STATUS, {20'h0, mode, 8'h1B});
    $display("test power_on_modes done");
    final_report();
  end
  initial
  begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    final_report();
  end
endmodule : test_drive_enable_comm_watchdog_units
